// [rcc_map.svh]
// Register indexes, field positions, reset values and timing counts of the counter control block.
`ifndef RCC_MAP_SVH
`define RCC_MAP_SVH

// Register indexes; the byte address is four times the index.
`define RCC_IDX_CTRL 6'h00
`define RCC_IDX_EVENT_OUTPUT_CONTROL 6'h04
`define RCC_IDX_IRQ_ENABLE_CLEAR 6'h08
`define RCC_IDX_IRQ_ENABLE_SET 6'h0A
`define RCC_IDX_IRQ_FLAG_STATUS 6'h0C
`define RCC_IDX_DEBUG_HALT_CONTROL 6'h0E
`define RCC_IDX_SYNC_PENDING_STATUS 6'h10

// Field positions.
`define RCC_CTRL_SOFT_RESET_BIT 0
`define RCC_CTRL_ENABLE 1
`define RCC_CTRL_MODE_LO 2
`define RCC_CTRL_PRESC_LO 8
`define RCC_BIT_OVF 15
`define RCC_BIT_ALARM 8
`define RCC_DBG_RUN 0

// Operating modes and special field values.
`define RCC_MODE_WIDE 2'h0
`define RCC_MODE_NARROW 2'h1
`define RCC_MODE_CAL 2'h2
`define RCC_MODE_RSVD 2'h3
`define RCC_PRESC_OFF 4'h0

// Reset values.
`define RCC_RST16 16'h0000
`define RCC_RST8 8'h00

// Timing: clock-domain synchronisation delay in aclk cycles, source tick divider.
`define RCC_SYNC_CYCLES 4'h4
`define RCC_SRC_DIV 16'h0008

// Bus responses.
`define RCC_RESP_OKAY 2'h0
`define RCC_RESP_SLVERR 2'h2

`endif

// [rcc_pkg.sv]
// Types shared by the counter control block.
package rcc_pkg;
	typedef enum logic [1:0] {
		RCC_SY_IDLE,
		RCC_SY_EN,
		RCC_SY_RST
	} rcc_sync_state_t;
endpackage

// [rcc_ctrl.sv]
// Control, event output and interrupt logic of the calendar counter, with an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "rcc_map.svh"

// Notes on behaviour
// R01 - Mode field selects wide, narrow, calendar; unsynchronised.
// R02 - Enable reads back at once; applied after sync.
// R03 - Soft reset clears all but debug control.
// R04 - Soft reset write discards its other fields.
// R05 - Soft reset bit reads one until done.
// R06 - Overflow event only when its enable set.
// R07 - Alarm event only when its enable set.
// R08 - Periodic event enables gate each interval event.
// R09 - Writing one to enable-clear clears enables.
// R10 - Writing one to enable-set sets enables.
// R11 - Set and clear registers read shared enables.
// R12 - Overflow flag set next counter tick after overflow.
// R13 - Alarm flag set next counter tick after match.
// R14 - Periodic flag x on prescaler bit x+2 rising.
// R15 - Writing one clears a flag; zero ignored.
// R16 - No periodic events while prescaler is off.
// R17 - Debug halt stops counter unless run bit set.
// R18 - One interrupt line, OR of enabled flags.
// R19 - Event outputs are single-cycle pulses per occurrence.

module rcc_ctrl
	import rcc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter logic [15:0] SRC_DIV = `RCC_SRC_DIV,
	parameter logic [3:0] SYNC_CYCLES = `RCC_SYNC_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic overflow_in,
	input wire logic alarm_match_in,
	input wire logic debug_halt,
	output logic counter_tick,
	output logic counter_enabled,
	output logic [1:0] counter_mode,
	output logic overflow_event,
	output logic alarm_zero_event,
	output logic [7:0] periodic_event,
	output logic irq
);

	// ********************************
	// Bus slave
	// ********************************
	logic aw_held_r;
	logic w_held_r;
	logic [5:0] aw_idx_r;
	logic [31:0] wdata_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic wr_go;
	logic rd_go;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_val;
	logic [15:0] wd;
	logic wr_ctrl, wr_ev, wr_clr, wr_set, wr_flag, wr_dbg;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_go = aw_held_r && w_held_r && !bvalid_r;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wd = wdata_r[15:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_idx_r <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_idx_r <= s_axi_awaddr[7:2];
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// Byte lanes without a strobe write zero, so a narrow write never leaves stale bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				wdata_r[i*8 +: 8] <= s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : 8'h00;
			end
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_comb begin
		wr_ctrl = wr_go && aw_idx_r == `RCC_IDX_CTRL;
		wr_ev = wr_go && aw_idx_r == `RCC_IDX_EVENT_OUTPUT_CONTROL;
		wr_clr = wr_go && aw_idx_r == `RCC_IDX_IRQ_ENABLE_CLEAR;
		wr_set = wr_go && aw_idx_r == `RCC_IDX_IRQ_ENABLE_SET;
		wr_flag = wr_go && aw_idx_r == `RCC_IDX_IRQ_FLAG_STATUS;
		wr_dbg = wr_go && aw_idx_r == `RCC_IDX_DEBUG_HALT_CONTROL;
		wr_hit = wr_ctrl || wr_ev || wr_clr || wr_set || wr_flag || wr_dbg
			|| aw_idx_r == `RCC_IDX_SYNC_PENDING_STATUS;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RCC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ********************************
	// Control and synchronisation
	// ********************************
	logic soft_reset_bit_r;
	logic enable_r;
	logic enable_eff_r;
	logic [1:0] mode_r;
	logic [3:0] presc_r;
	logic run_halted_r;
	rcc_sync_state_t sync_st_r;
	logic [3:0] sync_cnt_r;
	logic sw_clr;
	logic sync_done;

	assign sync_done = sync_st_r != RCC_SY_IDLE && sync_cnt_r == 4'h1;
	assign sw_clr = sync_st_r == RCC_SY_RST && sync_done;

	// R02 R05 sync sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			sync_st_r <= RCC_SY_IDLE;
			sync_cnt_r <= 4'h0;
		end else if (wr_ctrl && wd[`RCC_CTRL_SOFT_RESET_BIT]) begin
			sync_st_r <= RCC_SY_RST;
			sync_cnt_r <= SYNC_CYCLES;
		end else if (wr_ctrl && sync_st_r != RCC_SY_RST) begin
			sync_st_r <= RCC_SY_EN;
			sync_cnt_r <= SYNC_CYCLES;
		end else begin
			unique case (sync_st_r)
				RCC_SY_IDLE: sync_cnt_r <= 4'h0;
				RCC_SY_EN, RCC_SY_RST: begin
					sync_cnt_r <= sync_cnt_r - 4'h1;
					if (sync_done) begin
						sync_st_r <= RCC_SY_IDLE;
					end
				end
			endcase
		end
	end

	// R03 R04 R05 soft reset bit and fields it overrides
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			soft_reset_bit_r <= 1'b0;
			enable_r <= 1'b0;
			mode_r <= `RCC_MODE_WIDE;
			presc_r <= `RCC_PRESC_OFF;
		end else if (wr_ctrl && wd[`RCC_CTRL_SOFT_RESET_BIT]) begin
			soft_reset_bit_r <= 1'b1;
		end else if (wr_ctrl && !soft_reset_bit_r) begin
			enable_r <= wd[`RCC_CTRL_ENABLE];
			// R01 mode is enable-protected and applied unsynchronised
			if (!enable_r && !enable_eff_r) begin
				mode_r <= wd[`RCC_CTRL_MODE_LO +: 2];
				presc_r <= wd[`RCC_CTRL_PRESC_LO +: 4];
			end
		end
	end

	// R02 enable applied after the sync delay
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			enable_eff_r <= 1'b0;
		end else if (sync_st_r == RCC_SY_EN && sync_done) begin
			enable_eff_r <= enable_r;
		end
	end

	// R03 R17 debug run bit survives soft reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_halted_r <= 1'b0;
		end else if (wr_dbg) begin
			run_halted_r <= wd[`RCC_DBG_RUN];
		end
	end

	assign counter_enabled = enable_eff_r;
	assign counter_mode = mode_r;

	// ********************************
	// Prescaler and counter tick
	// ********************************
	logic [15:0] src_cnt_r;
	logic src_tick;
	logic running;
	logic [9:0] pres_cnt_r;
	logic [9:0] pres_prev_r;
	logic [9:0] pres_mask;
	logic pres_step_r;

	// R17 halt on debugger unless run bit set
	assign running = enable_eff_r && !(debug_halt && !run_halted_r);
	assign src_tick = src_cnt_r == SRC_DIV - 16'h0001;

	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr || src_tick) begin
			src_cnt_r <= 16'h0000;
		end else begin
			src_cnt_r <= src_cnt_r + 16'h0001;
		end
	end

	always_comb begin
		pres_mask = 10'h000;
		if (presc_r > 4'h1) begin
			pres_mask = 10'((11'h001 << (presc_r - 4'h1)) - 11'h001);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			pres_cnt_r <= 10'h000;
			pres_prev_r <= 10'h000;
			pres_step_r <= 1'b0;
			counter_tick <= 1'b0;
		end else begin
			pres_step_r <= src_tick && running;
			pres_prev_r <= pres_cnt_r;
			counter_tick <= src_tick && running && (pres_cnt_r & pres_mask) == pres_mask;
			if (src_tick && running) begin
				pres_cnt_r <= pres_cnt_r + 10'h001;
			end
		end
	end

	// ********************************
	// Flags, enables and events
	// ********************************
	logic [15:0] event_output_control_r;
	logic [15:0] inten_r;
	logic [15:0] flag_r;
	logic ovf_pend_r;
	logic alarm_pend_r;
	logic set_ovf;
	logic set_alarm;
	logic [7:0] per_rise;
	logic [7:0] set_per;
	logic [15:0] flag_set;

	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			ovf_pend_r <= 1'b0;
			alarm_pend_r <= 1'b0;
		end else begin
			ovf_pend_r <= overflow_in || (ovf_pend_r && !counter_tick);
			alarm_pend_r <= alarm_match_in || (alarm_pend_r && !counter_tick);
		end
	end

	// R12 R13 flags follow on the next counter tick
	assign set_ovf = counter_tick && ovf_pend_r;
	assign set_alarm = counter_tick && alarm_pend_r;
	// R14 R16 rising prescaler bit x+2, none while prescaler off
	assign per_rise = pres_cnt_r[9:2] & ~pres_prev_r[9:2];
	assign set_per = (presc_r == `RCC_PRESC_OFF) ? 8'h00 : per_rise & {8{pres_step_r}};

	always_comb begin
		flag_set = 16'h0000;
		flag_set[`RCC_BIT_OVF] = set_ovf;
		flag_set[`RCC_BIT_ALARM] = set_alarm;
		flag_set[7:0] = set_per;
	end

	// R15 clear by one, a set in the same cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			flag_r <= `RCC_RST16;
		end else begin
			flag_r <= ((wr_flag ? flag_r & ~wd : flag_r) | flag_set) & 16'h81FF;
		end
	end

	// R09 R10 R11 one shared enable set
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			inten_r <= `RCC_RST16;
		end else if (wr_set) begin
			inten_r <= (inten_r | wd) & 16'h81FF;
		end else if (wr_clr) begin
			inten_r <= inten_r & ~wd;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			event_output_control_r <= `RCC_RST16;
		end else if (wr_ev && !enable_r && !enable_eff_r) begin
			event_output_control_r <= wd & 16'h81FF;
		end
	end

	// R06 R07 R08 R19 gated single-cycle event pulses
	always_ff @(posedge aclk) begin
		if (!aresetn || sw_clr) begin
			overflow_event <= 1'b0;
			alarm_zero_event <= 1'b0;
			periodic_event <= 8'h00;
		end else begin
			overflow_event <= set_ovf && event_output_control_r[`RCC_BIT_OVF];
			alarm_zero_event <= set_alarm && event_output_control_r[`RCC_BIT_ALARM];
			periodic_event <= set_per & event_output_control_r[7:0];
		end
	end

	// R18 single interrupt line
	assign irq = |(flag_r & inten_r);

	// ********************************
	// Read path
	// ********************************
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr[7:2])
			`RCC_IDX_CTRL: rd_val[15:0] = {4'h0, presc_r, 4'h0, mode_r, enable_r, soft_reset_bit_r};
			`RCC_IDX_EVENT_OUTPUT_CONTROL: rd_val[15:0] = event_output_control_r;
			`RCC_IDX_IRQ_ENABLE_CLEAR, `RCC_IDX_IRQ_ENABLE_SET: rd_val[15:0] = inten_r;
			`RCC_IDX_IRQ_FLAG_STATUS: rd_val[15:0] = flag_r;
			`RCC_IDX_DEBUG_HALT_CONTROL: rd_val[0] = run_halted_r;
			`RCC_IDX_SYNC_PENDING_STATUS: rd_val[1:0] = {sync_st_r == RCC_SY_EN, sync_st_r == RCC_SY_RST};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RCC_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_soft_reset_bit_discard;
		wr_ctrl && wd[`RCC_CTRL_SOFT_RESET_BIT] |=> enable_r == $past(enable_r) && mode_r == $past(mode_r);
	endproperty
	a_soft_reset_bit_discard: assert property (p_soft_reset_bit_discard) else $error("soft reset write changed fields"); // R04

	property p_soft_reset_bit_hold;
		wr_ctrl && wd[`RCC_CTRL_SOFT_RESET_BIT] |=> soft_reset_bit_r [*4] ##1 !soft_reset_bit_r && !enable_eff_r;
	endproperty
	a_soft_reset_bit_hold: assert property (p_soft_reset_bit_hold) else $error("soft reset bit timing wrong"); // R05

	property p_enable_sync;
		wr_ctrl && !wd[`RCC_CTRL_SOFT_RESET_BIT] && !soft_reset_bit_r && sync_st_r != RCC_SY_RST
			|=> enable_r == $past(wd[`RCC_CTRL_ENABLE]) && sync_st_r == RCC_SY_EN;
	endproperty
	a_enable_sync: assert property (p_enable_sync) else $error("enable not read back at once"); // R02

	property p_en_clear;
		wr_clr && !wr_set |=> (inten_r & $past(wd)) == 16'h0000;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enable clear failed"); // R09

	property p_en_set;
		wr_set |=> (inten_r & $past(wd) & 16'h81FF) == ($past(wd) & 16'h81FF);
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set failed"); // R10

	property p_flag_clear;
		wr_flag && flag_set == 16'h0000 |=> (flag_r & $past(wd)) == 16'h0000;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag clear failed"); // R15

	property p_ovf_irq;
		set_ovf && inten_r[`RCC_BIT_OVF] && !sw_clr && !(wr_clr && wd[`RCC_BIT_OVF])
			|=> flag_r[`RCC_BIT_OVF] && irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow did not raise interrupt"); // R12

	property p_no_per_off;
		presc_r == `RCC_PRESC_OFF |-> set_per == 8'h00 ##1 periodic_event == 8'h00;
	endproperty
	a_no_per_off: assert property (p_no_per_off) else $error("periodic event with prescaler off"); // R16

	property p_ovf_gate;
		overflow_event |-> $past(event_output_control_r[`RCC_BIT_OVF]) && $past(set_ovf);
	endproperty
	a_ovf_gate: assert property (p_ovf_gate) else $error("ungated overflow event"); // R06

	property p_dbg_halt;
		debug_halt && !run_halted_r |=> !counter_tick;
	endproperty
	a_dbg_halt: assert property (p_dbg_halt) else $error("counter ticked while halted"); // R17

	c_soft_reset_bit: cover property (wr_ctrl && wd[`RCC_CTRL_SOFT_RESET_BIT] ##[1:8] sw_clr);
	c_irq: cover property (!irq ##1 irq);
	c_per_evt: cover property (periodic_event != 8'h00);
	c_ovf_evt: cover property (overflow_event);

endmodule
`default_nettype wire

// [rcc_ctrl_tb.sv]
// Self-checking testbench of the counter control block.
`timescale 1ns/1ps
`default_nettype none
`include "rcc_map.svh"

module rcc_ctrl_tb
	import rcc_pkg::*;
;
	// ********************************
	// Signals
	// ********************************
	logic aclk;
	logic aresetn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bry = 1'b0;
	logic arv = 1'b0;
	logic rry = 1'b0;
	logic ovf_in = 1'b0;
	logic alm_in = 1'b0;
	logic halt = 1'b0;
	logic awr, wr_rdy, bv, arr, rv, tick, en_o, ovf_ev, alm_ev, irq;
	logic [1:0] br, rr, mode_o;
	logic [31:0] rdat;
	logic [7:0] per_ev;
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 49;
	int ovf_n = 0;
	int alm_n = 0;
	int tick_n = 0;
	int per_n[8] = '{default: 0};

	// A short source divider keeps the periodic intervals within a few thousand cycles.
	rcc_ctrl #(.ADDR_W(8), .SRC_DIV(16'h0002), .SYNC_CYCLES(4'h4)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.overflow_in(ovf_in), .alarm_match_in(alm_in), .debug_halt(halt),
		.counter_tick(tick), .counter_enabled(en_o), .counter_mode(mode_o),
		.overflow_event(ovf_ev), .alarm_zero_event(alm_ev), .periodic_event(per_ev), .irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Pulse counters; the bench compares differences, so they never need clearing.
	always @(posedge aclk) begin
		ovf_n += ovf_ev;
		alm_n += alm_ev;
		tick_n += tick;
		for (int k = 0; k < 8; k++) begin
			per_n[k] += per_ev[k];
		end
	end

	// ********************************
	// Tasks
	// ********************************
	task automatic give_verdict();
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Expected shared enable word after a set or a clear access.
	function automatic logic [31:0] exp_en(input logic [31:0] old, input logic [31:0] m,
		input logic set);
		return set ? (old | m) : (old & ~m);
	endfunction

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [5:0] i, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ad;
		logic dd;
		@(posedge aclk);
		awa <= {i, 2'b00};
		wd <= d;
		ws <= 4'hF;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		ad = 1'b0;
		dd = 1'b0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awv && awr) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_rdy) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end while (!(ad && dd && bv) && n < 200);
		r = br;
		bry <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		ara <= {i, 2'b00};
		arv <= 1'b1;
		rry <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arv && arr) begin
				arv <= 1'b0;
			end
		end while (!rv && n < 200);
		d = rdat;
		r = rr;
		rry <= 1'b0;
	endtask

	task automatic rchk(input logic [5:0] i, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		logic [31:0] d;
		logic [1:0] r;
		rd(i, d, r);
		chk(nm, d & m, e);
	endtask

	task automatic pulse(input int which);
		@(posedge aclk);
		if (which == 0) ovf_in <= 1'b1; else alm_in <= 1'b1;
		@(posedge aclk);
		ovf_in <= 1'b0;
		alm_in <= 1'b0;
	endtask

	// ********************************
	// Watchdog
	// ********************************
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		give_verdict();
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		logic [31:0] d, ev, en, c;
		logic [1:0] r;
		logic [5:0] ids[6];
		int s[8];
		int t;
		int u;
		ids = '{`RCC_IDX_CTRL, `RCC_IDX_EVENT_OUTPUT_CONTROL, `RCC_IDX_IRQ_ENABLE_CLEAR, `RCC_IDX_IRQ_ENABLE_SET,
			`RCC_IDX_IRQ_FLAG_STATUS, `RCC_IDX_DEBUG_HALT_CONTROL};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (ids[k]) rchk(ids[k], 32'hFFFF_FFFF, 32'h0, "reset value");
		rd(6'h11, d, r);
		chk("unmapped read", {r, d[29:0]}, {`RCC_RESP_SLVERR, 30'h0});
		wr(6'h11, 32'hFFFF_FFFF, r);
		chk("unmapped write", r, `RCC_RESP_SLVERR);
		en = 32'h0;
		repeat (6) begin
			c = $random(seed) & 32'h81FF;
			wr(`RCC_IDX_IRQ_ENABLE_SET, c, r);
			en = exp_en(en, c, 1'b1);
			rchk(`RCC_IDX_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFF, en, "enables via clear");
			c = $random(seed) & 32'h81FF;
			wr(`RCC_IDX_IRQ_ENABLE_CLEAR, c, r);
			en = exp_en(en, c, 1'b0);
			rchk(`RCC_IDX_IRQ_ENABLE_SET, 32'hFFFF_FFFF, en, "enables via set");
		end
		wr(`RCC_IDX_IRQ_ENABLE_CLEAR, 32'hFFFF, r);
		for (int m = 0; m < 4; m++) begin
			wr(`RCC_IDX_CTRL, 32'(m) << 2, r);
			chk("mode output", mode_o, 32'(m));
		end
		wr(`RCC_IDX_CTRL, 32'h0, r);
		wr(`RCC_IDX_DEBUG_HALT_CONTROL, 32'h1, r);
		ev = 32'h8000 | ($random(seed) & 32'hFF);
		wr(`RCC_IDX_EVENT_OUTPUT_CONTROL, ev, r);
		rchk(`RCC_IDX_EVENT_OUTPUT_CONTROL, 32'h81FF, ev, "event control");
		wr(`RCC_IDX_CTRL, 32'h0108, r);
		wr(`RCC_IDX_CTRL, 32'h010A, r);
		rchk(`RCC_IDX_SYNC_PENDING_STATUS, 32'h2, 32'h2, "enable busy set");
		rchk(`RCC_IDX_CTRL, 32'h2, 32'h2, "enable readback");
		t = 0;
		while (en_o !== 1'b1 && t < 50) begin
			@(posedge aclk);
			t++;
		end
		chk("counter enabled", en_o, 32'h1);
		rchk(`RCC_IDX_SYNC_PENDING_STATUS, 32'h2, 32'h0, "enable busy done");
		wr(`RCC_IDX_IRQ_ENABLE_SET, 32'h8000, r);
		wr(`RCC_IDX_IRQ_FLAG_STATUS, 32'hFFFF, r);
		s = per_n;
		repeat (2200) @(posedge aclk);
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'hFF, 32'hFF, "periodic flags");
		for (int k = 0; k < 8; k++) chk("periodic event", per_n[k] > s[k], ev[k]);
		wr(`RCC_IDX_IRQ_FLAG_STATUS, 32'hFFFF, r);
		t = ovf_n;
		pulse(0);
		repeat (20) @(posedge aclk);
		chk("overflow events", ovf_n - t, 32'h1);
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'h8100, 32'h8000, "overflow flag");
		chk("irq overflow", irq, 32'h1);
		wr(`RCC_IDX_IRQ_FLAG_STATUS, 32'h0, r);
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'h8100, 32'h8000, "flag kept");
		wr(`RCC_IDX_IRQ_FLAG_STATUS, 32'h8000, r);
		chk("irq cleared", irq, 32'h0);
		t = alm_n;
		pulse(1);
		repeat (20) @(posedge aclk);
		chk("alarm events", alm_n - t, 32'h0);
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'h8100, 32'h0100, "alarm flag");
		chk("irq masked", irq, 32'h0);
		wr(`RCC_IDX_IRQ_ENABLE_SET, 32'h0100, r);
		chk("irq alarm", irq, 32'h1);
		wr(`RCC_IDX_IRQ_FLAG_STATUS, 32'h0100, r);
		chk("irq alarm cleared", irq, 32'h0);
		halt <= 1'b1;
		t = tick_n;
		repeat (20) @(posedge aclk);
		chk("ticks while run bit set", tick_n > t, 32'h1);
		wr(`RCC_IDX_DEBUG_HALT_CONTROL, 32'h0, r);
		repeat (2) @(posedge aclk);
		t = tick_n;
		repeat (20) @(posedge aclk);
		chk("ticks while halted", tick_n - t, 32'h0);
		wr(`RCC_IDX_DEBUG_HALT_CONTROL, 32'h1, r);
		halt <= 1'b0;
		wr(`RCC_IDX_CTRL, 32'h020B, r);
		rchk(`RCC_IDX_CTRL, 32'h1, 32'h1, "reset busy");
		repeat (10) @(posedge aclk);
		rchk(`RCC_IDX_CTRL, 32'hFFFF, 32'h0, "control after reset");
		chk("enable after reset", {mode_o, en_o}, 32'h0);
		rchk(`RCC_IDX_EVENT_OUTPUT_CONTROL, 32'hFFFF, 32'h0, "event control reset");
		rchk(`RCC_IDX_IRQ_ENABLE_SET, 32'hFFFF, 32'h0, "enables reset");
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'hFFFF, 32'h0, "flags reset");
		rchk(`RCC_IDX_DEBUG_HALT_CONTROL, 32'h1, 32'h1, "run bit kept");
		wr(`RCC_IDX_EVENT_OUTPUT_CONTROL, 32'h1FF, r);
		wr(`RCC_IDX_CTRL, 32'h0008, r);
		wr(`RCC_IDX_CTRL, 32'h000A, r);
		s = per_n;
		repeat (2200) @(posedge aclk);
		rchk(`RCC_IDX_IRQ_FLAG_STATUS, 32'hFF, 32'h0, "no periodic flags");
		for (int k = 0; k < 8; k++) chk("no periodic event", per_n[k] - s[k], 32'h0);
		t = alm_n;
		u = ovf_n;
		pulse(1);
		pulse(0);
		repeat (20) @(posedge aclk);
		chk("alarm event enabled", alm_n - t, 32'h1);
		chk("overflow event disabled", ovf_n - u, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
